// file: dv/host_port_model.sv
// Host side of the two sample ports: transmit frames, receive wait
// Assumes the port clocks come from the datapath under test
`timescale 1ns/100ps
module host_port_model (
   input  wire logic        i_txp_clk,
   input  wire logic        i_rxp_clk,
   input  wire logic [15:0] i_word,
   output logic             o_start,
   output logic             o_enable,
   output logic [15:0]      o_data,
   output logic             o_wait
);
   int slot = 0;
   int n    = 0;
   // ****
   // Transmit frames
   // ****
   initial begin
      o_start = 1'b0;
      o_enable = 1'b0;
      o_data = 16'h0000;
      o_wait = 1'b0;
   end
   always @(posedge i_txp_clk) begin
      #1;
      slot = (slot + 1) % 10;
      o_start = slot == 0;
      o_enable = slot != 8;
      o_data = (slot == 8) ? ~o_data : i_word;
   end
   always @(posedge i_rxp_clk) begin
      #1;
      n = n + 1;
      o_wait = n[2];
   end
endmodule // host_port_model

// file: dv/tb.sv
// Self-checking bench of the converter port datapath
// Assumes host_port_model on the ports and a free-running ADC clock
`timescale 1ns/100ps
module tb;
   logic i_mclk = 0, i_rst = 1, i_adc_clk = 0, i_ddr = 0, i_wide = 1;
   logic i_bypass = 0, i_lo_we = 0, o_txp_clk, o_dac_clk, o_rxp_clk;
   logic o_rxp_start, o_rxp_enable, o_rx_overrun;
   logic i_txp_start, i_txp_enable, i_rxp_wait, f, rx_chk = 0, prev_i;
   logic [7:0]  i_tx_half = 8'h02, i_rx_half = 8'h01;
   logic [15:0] i_adc_data, i_lo_sin, i_lo_cos, i_txp_data, o_rxp_data;
   logic [15:0] i_decim = 16'h0040, rnd = 16'h1bbf, word, exp_i, exp_q;
   logic [31:0] i_phase_inc;
   logic [5:0]  i_out_shift = 6'h02;
   logic [9:0]  i_lo_addr = 10'h000;
   logic [13:0] o_dac_data;
   logic signed [47:0] si, sq;
   logic [15:0] txq[$];
   logic prev_clk = 0;
   int errors = 0, n_compared = 0, rx_seen = 0;
   realtime last = 0;
   sdr_converter_port_datapath uut (.i_mclk, .i_rst, .i_adc_clk, .i_adc_data,
      .i_tx_half, .i_rx_half, .i_ddr, .i_wide, .i_bypass, .i_decim, .i_phase_inc,
      .i_out_shift, .i_lo_we, .i_lo_addr, .i_lo_sin, .i_lo_cos, .o_txp_clk,
      .i_txp_start, .i_txp_enable, .i_txp_data, .o_dac_clk, .o_dac_data,
      .o_rxp_clk, .o_rxp_start, .o_rxp_enable, .o_rxp_data, .i_rxp_wait,
      .o_rx_overrun);
   host_port_model host (.i_txp_clk(o_txp_clk), .i_rxp_clk(o_rxp_clk),
      .i_word(word), .o_start(i_txp_start), .o_enable(i_txp_enable),
      .o_data(i_txp_data), .o_wait(i_rxp_wait));
   // ****
   // Clocks and helpers
   // ****
   always #5 i_mclk = ~i_mclk;
   initial begin
      #3;
      forever #6 i_adc_clk = ~i_adc_clk;
   end
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wrap_up;
      $display("compared %0d mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic hold_reset;
      i_rst = 1;
      last = 0;
      f = 0;
      repeat (10) @(posedge i_mclk);
      #1 chk({2'b00, o_dac_data}, 16'h0000);
      i_rst = 0;
   endtask
   // ****
   // Transmit notes and compares
   // ****
   always @(posedge o_txp_clk) begin
      if (last > 0) chk(16'($rtoi($realtime - last)), 16'(20 * i_tx_half));
      last = $realtime;
      if (!i_txp_enable) f = 0;
      else if (i_txp_start || f) begin
         f = 1;
         txq.push_back(i_wide ? {2'b00, i_txp_data[13:0]} : {2'b00, i_txp_data[7:0], 6'h00});
      end
      word = lfsr(word);
   end
   always @(posedge o_txp_clk) begin
      #2;
      chk({15'h0, o_dac_clk}, {15'h0, ~o_txp_clk});
      if (txq.size() > 0) chk({2'b00, o_dac_data}, txq.pop_front());
   end
   // ****
   // Receive compares
   // ****
   always @(negedge i_mclk) begin
      if ((o_rxp_clk != prev_clk) && (i_ddr || !o_rxp_clk) && rx_chk && o_rxp_enable) begin
         chk(o_rxp_data, o_rxp_start ? exp_i : exp_q);
         if (rx_seen > 0) chk({15'h0, o_rxp_start}, {15'h0, !prev_i});
         prev_i = o_rxp_start;
         rx_seen++;
      end
      prev_clk = o_rxp_clk;
   end
   // ****
   // Main sequence and watchdog
   // ****
   initial begin
      i_adc_data = rnd;
      i_lo_cos = lfsr(rnd);
      i_lo_sin = lfsr(i_lo_cos);
      word = lfsr(i_lo_sin);
      i_phase_inc = {word, rnd};
      si = $signed(i_adc_data) * $signed(i_lo_cos);
      sq = $signed(i_adc_data) * $signed(i_lo_sin);
      si = si * 64;
      sq = sq * 64;
      exp_i = si[17:2];
      exp_q = sq[17:2];
      hold_reset;
      for (int k = 0; k < 1024; k++) begin
         @(posedge i_mclk);
         #1 i_lo_we = 1;
         i_lo_addr = 10'(k);
      end
      @(posedge i_mclk);
      #1 i_lo_we = 0;
      repeat (200) @(posedge i_mclk);
      rx_chk = 1;
      repeat (3000) @(posedge i_mclk);
      chk({15'h0, o_rx_overrun}, 16'h0000);
      chk({15'h0, rx_seen != 0}, 16'h0001);
      $display("test mixed done");
      rx_chk = 0;
      rx_seen = 0;
      @(posedge i_mclk);
      #1 i_rst = 1;
      {i_wide, i_bypass, i_tx_half, i_rx_half} = {2'b01, 8'h03, 8'h02};
      exp_i = {8'h00, i_adc_data[15:8]};
      exp_q = exp_i;
      hold_reset;
      repeat (50) @(posedge i_mclk);
      rx_chk = 1;
      repeat (2000) @(posedge i_mclk);
      chk({15'h0, o_rx_overrun}, 16'h0001);
      chk({15'h0, rx_seen != 0}, 16'h0001);
      $display("test bypass done");
      rx_chk = 0;
      rx_seen = 0;
      @(posedge i_mclk);
      #1 i_rst = 1;
      {i_ddr, i_wide} = 2'b11;
      exp_i = i_adc_data;
      exp_q = exp_i;
      hold_reset;
      repeat (50) @(posedge i_mclk);
      rx_chk = 1;
      repeat (2000) @(posedge i_mclk);
      chk({15'h0, o_rx_overrun}, 16'h0001);
      chk({15'h0, rx_seen != 0}, 16'h0001);
      $display("test double rate done");
      wrap_up;
   end
   initial begin
      #200000;
      errors++;
      wrap_up;
   end
endmodule // tb

// file: hw/pair_fifo.sv
// Small word buffer with valid and ready on both sides
// Assumes a single clock and a synchronous active-high reset
`timescale 1ns/100ps
module pair_fifo #(
   parameter int W     = 32,
   parameter int DEPTH = 2
) (
   input logic     i_mclk,
   input logic     i_rst,
   stream_if.snk   s_in,
   stream_if.src   s_out
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
   localparam logic [AW:0]   FULL = (AW + 1)'(DEPTH);

   logic [W-1:0]  mem [DEPTH];
   logic [AW-1:0] wr;
   logic [AW-1:0] rd;
   logic [AW:0]   cnt;
   logic [AW-1:0] next_wr;
   logic [AW-1:0] next_rd;
   logic [AW:0]   next_cnt;
   logic          push;
   logic          pop;

   assign s_in.ready  = (cnt != FULL);
   assign s_out.valid = (cnt != '0);
   assign s_out.data  = mem[rd];

   // ************************************************************
   // Pointers and fill level
   // ************************************************************
   always_comb begin
      push     = s_in.valid && s_in.ready;
      pop      = s_out.valid && s_out.ready;
      next_wr  = wr;
      next_rd  = rd;
      next_cnt = cnt;
      if (push) begin
         next_wr = (wr == LAST) ? '0 : wr + 1'b1;
      end
      if (pop) begin
         next_rd = (rd == LAST) ? '0 : rd + 1'b1;
      end
      if (push && !pop) begin
         next_cnt = cnt + 1'b1;
      end else if (pop && !push) begin
         next_cnt = cnt - 1'b1;
      end
   end

   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         wr  <= '0;
         rd  <= '0;
         cnt <= '0;
      end else begin
         wr  <= next_wr;
         rd  <= next_rd;
         cnt <= next_cnt;
      end
   end

   always_ff @(posedge i_mclk) begin
      if (push) begin
         mem[wr] <= s_in.data;
      end
   end

   // Fill level bounded
   fill_bound_a: assert property (@(posedge i_mclk) disable iff (i_rst)
      (cnt == FULL) |=> (cnt == FULL) || (cnt == FULL - 1'b1))
      else $error("buffer fill level jumped from full");
endmodule // pair_fifo

// file: hw/sdr_converter_port_datapath.sv
// Converter port datapath: transmit forwarding to the DAC, receive
// mixing and integration, and the two host sample ports.
// Assumes i_mclk is the port-side clock, i_adc_clk the free-running
// converter clock, and configuration inputs static while in use.
`timescale 1ns/100ps

module sdr_converter_port_datapath
   import sdr_pkg::*;
#(
   parameter int LOG2_LO    = LO_AW,
   parameter int FIFO_DEPTH = BUF_DEPTH
) (
   input  logic                i_mclk,
   input  logic                i_rst,
   input  logic                i_adc_clk,
   input  logic [SAMPLE_W-1:0] i_adc_data,
   input  logic [DIV_W-1:0]    i_tx_half,
   input  logic [DIV_W-1:0]    i_rx_half,
   input  logic                i_ddr,
   input  logic                i_wide,
   input  logic                i_bypass,
   input  logic [DEC_W-1:0]    i_decim,
   input  logic [PH_W-1:0]     i_phase_inc,
   input  logic [SHIFT_W-1:0]  i_out_shift,
   input  logic                i_lo_we,
   input  logic [LOG2_LO-1:0]  i_lo_addr,
   input  logic [SAMPLE_W-1:0] i_lo_sin,
   input  logic [SAMPLE_W-1:0] i_lo_cos,
   output logic                o_txp_clk,
   input  logic                i_txp_start,
   input  logic                i_txp_enable,
   input  logic [SAMPLE_W-1:0] i_txp_data,
   output logic                o_dac_clk,
   output logic [DAC_W-1:0]    o_dac_data,
   output logic                o_rxp_clk,
   output logic                o_rxp_start,
   output logic                o_rxp_enable,
   output logic [SAMPLE_W-1:0] o_rxp_data,
   input  logic                i_rxp_wait,
   output logic                o_rx_overrun
);
   function automatic logic [SAMPLE_W-1:0] fmt(input logic [SAMPLE_W-1:0] w,
                                                input logic wide);
      return wide ? w : {{BYTE_W{1'b0}}, w[SAMPLE_W-1 -: BYTE_W]};
   endfunction

   function automatic logic [SAMPLE_W-1:0] scale(input logic signed [ACC_W-1:0] a,
                                                  input logic [SHIFT_W-1:0] sh);
      logic signed [ACC_W-1:0] t;
      t = a >>> sh;
      return t[SAMPLE_W-1:0];
   endfunction

   // ************************************************************
   // Host pin synchronisers
   // ************************************************************
   logic [SAMPLE_W+1:0] txp_s1;
   logic [SAMPLE_W+1:0] txp_s2;
   logic                wait_s1;
   logic                wait_s2;
   logic                tx_start;
   logic                tx_en;

   always_ff @(posedge i_mclk) begin
      txp_s1  <= {i_txp_start, i_txp_enable, i_txp_data};
      txp_s2  <= txp_s1;
      wait_s1 <= i_rxp_wait;
      wait_s2 <= wait_s1;
   end
   assign tx_start = txp_s2[SAMPLE_W+1];
   assign tx_en    = txp_s2[SAMPLE_W];

   // ************************************************************
   // Port clock dividers, 0 transmit and 1 receive
   // ************************************************************
   logic [DIV_W-1:0] half     [2];
   logic [DIV_W-1:0] cnt      [2];
   logic [DIV_W-1:0] next_cnt [2];
   logic             pclk     [2];
   logic             next_pclk[2];
   logic             tick     [2];

   assign half[0] = (i_tx_half < TX_HALF_MIN) ? TX_HALF_MIN : i_tx_half;
   assign half[1] = (i_rx_half < RX_HALF_MIN) ? RX_HALF_MIN : i_rx_half;

   for (genvar g = 0; g < 2; g++) begin : g_div
      always_comb begin
         tick[g]      = (cnt[g] >= half[g] - 8'h01);
         next_cnt[g]  = tick[g] ? '0 : cnt[g] + 8'h01;
         next_pclk[g] = pclk[g] ^ tick[g];
      end
      always_ff @(posedge i_mclk) begin
         if (i_rst) begin
            cnt[g]  <= '0;
            pclk[g] <= 1'b0;
         end else begin
            cnt[g]  <= next_cnt[g];
            pclk[g] <= next_pclk[g];
         end
      end
   end

   // ************************************************************
   // Transmit forwarding
   // ************************************************************
   logic             tx_take;
   logic             tx_run;
   logic             next_run;
   logic             dac_clk;
   logic [DAC_W-1:0] dac;
   logic [DAC_W-1:0] next_dac;

   always_comb begin
      // Capture on rise, or both edges in double rate
      tx_take  = tick[0] && (!pclk[0] || i_ddr);
      next_run = tx_run;
      next_dac = dac;
      if (tx_take) begin
         if (!tx_en) begin
            next_run = 1'b0;
         end else if (tx_start) begin
            next_run = 1'b1;
         end
         // Low bits or byte to DAC word
         if (tx_en && (tx_start || tx_run)) begin
            next_dac = i_wide ? txp_s2[DAC_W-1:0]
                              : {txp_s2[BYTE_W-1:0], {(DAC_W-BYTE_W){1'b0}}};
         end
      end
   end

   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         tx_run  <= 1'b0;
         dac     <= DAC_RST;
         dac_clk <= 1'b1;
      end else begin
         tx_run  <= next_run;
         dac     <= next_dac;
         // DAC clock from the port divider
         dac_clk <= !next_pclk[0];
      end
   end
   assign o_txp_clk  = pclk[0];
   assign o_dac_clk  = dac_clk;
   assign o_dac_data = dac;

   // ************************************************************
   // Local oscillator table, written on i_mclk, read on i_adc_clk
   // ************************************************************
   logic [PAIR_W-1:0] lo_ram [2**LOG2_LO];
   logic [PAIR_W-1:0] lo_rd;

   always_ff @(posedge i_mclk) begin
      if (i_lo_we) begin
         lo_ram[i_lo_addr] <= {i_lo_cos, i_lo_sin};
      end
   end

   // ************************************************************
   // Converter domain: reset, configuration and result crossing
   // ************************************************************
   logic                       arst_s1;
   logic                       arst;
   logic [CFG_W-1:0]           cfg_s1;
   logic [CFG_W-1:0]           cfg_s2;
   logic                       ack;
   logic                       ack_s1;
   logic                       ack_s2;
   logic                       a_bypass;
   logic [DEC_W-1:0]           a_decim;
   logic [PH_W-1:0]            a_inc;
   logic [SHIFT_W-1:0]         a_shift;

   always_ff @(posedge i_adc_clk) begin
      arst_s1 <= i_rst;
      arst    <= arst_s1;
      cfg_s1  <= {i_bypass, i_decim, i_phase_inc, i_out_shift};
      cfg_s2  <= cfg_s1;
      ack_s1  <= ack;
      ack_s2  <= ack_s1;
   end
   assign {a_bypass, a_decim, a_inc, a_shift} = cfg_s2;

   // ************************************************************
   // Mixer and integrator
   // ************************************************************
   logic signed [SAMPLE_W-1:0] samp;
   logic signed [SAMPLE_W-1:0] lo_c;
   logic signed [SAMPLE_W-1:0] lo_s;
   logic signed [PROD_W-1:0]   prod_i;
   logic signed [PROD_W-1:0]   prod_q;
   logic signed [ACC_W-1:0]    acc_i;
   logic signed [ACC_W-1:0]    acc_q;
   logic signed [ACC_W-1:0]    sum_i;
   logic signed [ACC_W-1:0]    sum_q;
   logic signed [ACC_W-1:0]    next_acc_i;
   logic signed [ACC_W-1:0]    next_acc_q;
   logic [PH_W-1:0]            phase;
   logic [PH_W-1:0]            next_phase;
   logic [DEC_W-1:0]           dcnt;
   logic [DEC_W-1:0]           next_dcnt;
   logic [DEC_W-1:0]           dec_m1;
   logic [SAMPLE_W-1:0]        first;
   logic [SAMPLE_W-1:0]        next_first;
   logic                       ptog;
   logic                       next_ptog;
   logic                       last;
   logic                       busy;
   logic                       ev;
   logic [SAMPLE_W-1:0]        ev_i;
   logic [SAMPLE_W-1:0]        ev_q;
   logic                       req;
   logic                       next_req;
   logic                       drop;
   logic                       next_drop;
   logic [PAIR_W-1:0]          xhold;
   logic [PAIR_W-1:0]          next_xhold;

   assign {lo_c, lo_s} = lo_rd;

   always_comb begin
      prod_i     = samp * lo_c;
      prod_q     = samp * lo_s;
      sum_i      = acc_i + {{(ACC_W-PROD_W){prod_i[PROD_W-1]}}, prod_i};
      sum_q      = acc_q + {{(ACC_W-PROD_W){prod_q[PROD_W-1]}}, prod_q};
      dec_m1     = (a_decim == '0) ? '0 : a_decim - 16'h0001;
      last       = (dcnt >= dec_m1);
      next_phase = phase + a_inc;
      next_acc_i = acc_i;
      next_acc_q = acc_q;
      next_dcnt  = dcnt;
      next_first = first;
      next_ptog  = 1'b0;
      ev         = 1'b0;
      ev_i       = '0;
      ev_q       = '0;
      if (a_bypass) begin
         // Raw samples paired two at a time
         next_ptog  = !ptog;
         next_first = ptog ? first : samp;
         ev         = ptog;
         ev_i       = first;
         ev_q       = samp;
      end else begin
         ev        = last;
         ev_i      = scale(sum_i, a_shift);
         ev_q      = scale(sum_q, a_shift);
         next_acc_i = last ? '0 : sum_i;
         next_acc_q = last ? '0 : sum_q;
         next_dcnt  = last ? '0 : dcnt + 16'h0001;
      end
      busy       = req ^ ack_s2;
      next_req   = req;
      next_drop  = drop;
      next_xhold = xhold;
      if (ev && !busy) begin
         next_xhold = {ev_i, ev_q};
         next_req   = !req;
      end else if (ev) begin
         next_drop = !drop;
      end
   end

   always_ff @(posedge i_adc_clk) begin
      if (arst) begin
         samp  <= '0;
         phase <= '0;
         acc_i <= '0;
         acc_q <= '0;
         dcnt  <= '0;
         first <= '0;
         ptog  <= 1'b0;
         req   <= 1'b0;
         drop  <= 1'b0;
         xhold <= '0;
      end else begin
         samp  <= i_adc_data;
         phase <= next_phase;
         acc_i <= next_acc_i;
         acc_q <= next_acc_q;
         dcnt  <= next_dcnt;
         first <= next_first;
         ptog  <= next_ptog;
         req   <= next_req;
         drop  <= next_drop;
         xhold <= next_xhold;
      end
   end

   always_ff @(posedge i_adc_clk) begin
      lo_rd <= lo_ram[phase[PH_W-1 -: LOG2_LO]];
   end

   // ************************************************************
   // Result intake on i_mclk and two-entry buffer
   // ************************************************************
   stream_if #(.W(PAIR_W)) fi ();
   stream_if #(.W(PAIR_W)) fo ();
   logic req_s1;
   logic req_s2;
   logic next_ack;
   logic drop_s1;
   logic drop_s2;
   logic drop_d;
   logic overrun;
   logic next_overrun;

   always_ff @(posedge i_mclk) begin
      req_s1  <= req;
      req_s2  <= req_s1;
      drop_s1 <= drop;
      drop_s2 <= drop_s1;
   end

   assign fi.valid = req_s2 ^ ack;
   assign fi.data  = xhold;

   always_comb begin
      next_ack     = ack ^ (fi.valid && fi.ready);
      next_overrun = overrun || (drop_s2 ^ drop_d);
   end

   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         ack     <= 1'b0;
         drop_d  <= 1'b0;
         overrun <= 1'b0;
      end else begin
         ack     <= next_ack;
         drop_d  <= drop_s2;
         overrun <= next_overrun;
      end
   end
   assign o_rx_overrun = overrun;

   pair_fifo #(.W(PAIR_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .i_mclk (i_mclk),
      .i_rst  (i_rst),
      .s_in   (fi),
      .s_out  (fo)
   );

   // ************************************************************
   // Receive port sender
   // ************************************************************
   send_st_t            st;
   send_st_t            next_st;
   logic [SAMPLE_W-1:0] rdata;
   logic [SAMPLE_W-1:0] next_rdata;
   logic [SAMPLE_W-1:0] qhold;
   logic [SAMPLE_W-1:0] next_qhold;
   logic                ren;
   logic                next_ren;
   logic                rstart;
   logic                next_rstart;
   logic                launch;
   logic                pop;

   always_comb begin
      launch      = tick[1] && (pclk[1] || i_ddr);
      next_st     = st;
      next_rdata  = rdata;
      next_qhold  = qhold;
      next_ren    = ren;
      next_rstart = rstart;
      pop         = 1'b0;
      if (launch) begin
         case (st)
            SND_I: begin
               next_rstart = 1'b0;
               // Wait holds the Q word back
               next_ren    = !wait_s2;
               if (!wait_s2) begin
                  next_rdata = fmt(qhold, i_wide);
                  next_st    = SND_Q;
               end
            end
            default: begin
               if (fo.valid && !wait_s2) begin
                  pop         = 1'b1;
                  next_rdata  = fmt(fo.data[PAIR_W-1 -: SAMPLE_W], i_wide);
                  next_qhold  = fo.data[SAMPLE_W-1:0];
                  next_ren    = 1'b1;
                  next_rstart = 1'b1;
                  next_st     = SND_I;
               end else begin
                  next_ren    = 1'b0;
                  next_rstart = 1'b0;
                  next_st     = SND_IDLE;
               end
            end
         endcase
      end
   end
   assign fo.ready = pop;

   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         st     <= SND_IDLE;
         rdata  <= '0;
         qhold  <= '0;
         ren    <= 1'b0;
         rstart <= 1'b0;
      end else begin
         st     <= next_st;
         rdata  <= next_rdata;
         qhold  <= next_qhold;
         ren    <= next_ren;
         rstart <= next_rstart;
      end
   end
   assign o_rxp_clk    = pclk[1];
   assign o_rxp_data   = rdata;
   assign o_rxp_enable = ren;
   assign o_rxp_start  = rstart;

   // ************************************************************
   // Checks
   // ************************************************************
   tx_clk_half_a: assert property (
      @(posedge i_mclk) disable iff (i_rst)
      $rose(o_txp_clk) |-> o_txp_clk ##1 o_txp_clk)
      else $error("transmit port clock high for under two cycles");
   dac_clk_a: assert property (
      @(posedge i_mclk) disable iff (i_rst) o_dac_clk != o_txp_clk)
      else $error("DAC clock not tied to transmit port clock");
   tx_fwd_a: assert property (
      @(posedge i_mclk) disable iff (i_rst)
      tx_take && tx_en && (tx_start || tx_run) && i_wide
      |=> o_dac_data == $past(i_txp_data[DAC_W-1:0], 3))
      else $error("transmit word not forwarded to DAC");
   start_en_a: assert property (
      @(posedge i_mclk) disable iff (i_rst) o_rxp_start |-> o_rxp_enable)
      else $error("start without enable on receive port");
   rx_data_a: assert property (
      @(posedge i_mclk) disable iff (i_rst)
      $changed(o_rxp_data) |-> $past(launch))
      else $error("receive data moved off a launch edge");
   phase_a: assert property (
      @(posedge i_adc_clk) disable iff (arst)
      !$past(arst) |-> phase == $past(phase) + $past(a_inc))
      else $error("phase did not advance by the step");
   dump_a: assert property (
      @(posedge i_adc_clk) disable iff (arst)
      !a_bypass && last |=> acc_i == '0 && acc_q == '0 && dcnt == '0)
      else $error("integrator not cleared after dump");
   result_a: assert property (
      @(posedge i_adc_clk) disable iff (arst)
      !a_bypass && last && !busy
      |=> req != $past(req) && xhold == {$past(ev_i), $past(ev_q)})
      else $error("integrated pair not handed over");
   bypass_a: assert property (
      @(posedge i_adc_clk) disable iff (arst)
      a_bypass && ptog && !busy |=> xhold == {$past(first), $past(samp)})
      else $error("raw sample pair not passed through");
endmodule // sdr_converter_port_datapath

// file: hw/sdr_pkg.sv
// Shared constants and types of the converter port datapath
// Assumes one transmit port, one receive port, one ADC and one DAC
package sdr_pkg;
   // ************************************************************
   // Widths
   // ************************************************************
   localparam int SAMPLE_W  = 16;
   localparam int BYTE_W    = 8;
   localparam int DAC_W     = 14;
   localparam int PROD_W    = 2 * SAMPLE_W;
   localparam int PAIR_W    = 2 * SAMPLE_W;
   localparam int ACC_W     = 48;
   localparam int PH_W      = 32;
   localparam int LO_AW     = 10;
   localparam int DIV_W     = 8;
   localparam int DEC_W     = 16;
   localparam int SHIFT_W   = 6;
   localparam int BUF_DEPTH = 2;
   localparam int CFG_W     = 1 + DEC_W + PH_W + SHIFT_W;

   // ************************************************************
   // Divider limits and reset values
   // ************************************************************
   localparam logic [DIV_W-1:0] TX_HALF_MIN = 8'h02;
   localparam logic [DIV_W-1:0] RX_HALF_MIN = 8'h01;
   localparam logic [DAC_W-1:0] DAC_RST     = 14'h0000;

   // ************************************************************
   // Receive port sender states
   // ************************************************************
   typedef enum logic [2:0] {
      SND_IDLE = 3'b001,
      SND_I    = 3'b010,
      SND_Q    = 3'b100
   } send_st_t;
endpackage

// file: hw/stream_if.sv
// Valid/ready word stream between the datapath and its buffer
// Assumes both ends sit on the same clock
`timescale 1ns/100ps
interface stream_if #(parameter int W = 32);
   logic         valid;
   logic         ready;
   logic [W-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface
